// ==== hw/eeprom_ctl.sv ====
// Purpose: Key-guarded, self-timed erase/write control for a data EEPROM.
// Assumes: One clock; reset cause inputs arrive from pins.
// Notes: The array is held in flops and stands in for the cell array.
// Functional notes
// - Array occupies 7FFE00h to 7FFFFFh.
// - Array holds 256 words.
// - Each word is 16 bits.
// - Every word individually read and written.
// - Operations never stall the processor.
// - Key port is write-only.
// - Correct pair opens one-cycle control window.
// - Bit 15 starts; software cannot clear.
// - Bit 14 enables; cleared on completion.
// - Bit 13 flags reset-aborted write.
// - Bit 12 skips automatic pre-erase.
// - Bit 6 selects erase versus write.
// - Codes erase eight, four, one words.
// - Code 0100xx erases whole array.
// - Code 0001xx writes one latched word.
// - Bits 11 to 7 read zero.
// - Undefined codes run the timed cycle and set the flag, but change no word.
// - Target address captures table-write address.
// - Target address bit zero always zero.
// - Completion sets the interrupt flag.
`default_nettype none
module eeprom_ctl #(
   parameter int WORDS = 256,
   parameter int OP_LEN = eeprom_ctl_pkg::OP_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   input wire logic table_write,
   input wire logic [23:0] table_address,
   input wire logic [15:0] table_wdata,
   input wire logic table_read,
   input wire logic [23:0] table_read_address,
   output logic [15:0] table_rdata,
   input wire logic external_master_clear,
   input wire logic watchdog_timeout,
   output logic completion_interrupt_flag,
   output logic busy
);
   typedef enum logic [1:0] {IDLE, RUN} state_type;
   typedef enum logic [1:0] {NONE, GOT_FIRST, OPEN} key_type;
   localparam int AW = $clog2(WORDS);

   state_type state, next_state;
   key_type key, next_key;
   logic [15:0] control, next_control;
   logic [23:0] target, next_target;
   logic [15:0] latch, next_latch;
   logic [15:0] mem [WORDS];
   logic [31:0] count, next_count;
   logic flag, next_flag;
   logic [15:0] next_rdata;
   logic [1:0] external_master_clear_sync, wdt_sync;
   logic abort_seen;
   logic start_ok;
   logic finish;
   logic [AW-1:0] tidx;
   logic [AW-1:0] span;
   logic do_erase, do_write;

   // Word index inside the array; bit zero of the address is dropped.
   assign tidx = target[AW:1];
   assign start_ok = reg_write && reg_addr == eeprom_ctl_pkg::ADDR_CONTROL
      && key == OPEN && reg_wdata[eeprom_ctl_pkg::BIT_TRIGGER]
      && control[eeprom_ctl_pkg::BIT_ENABLE];
   assign finish = state == RUN && count == 32'(OP_LEN - 1);
   assign busy = state == RUN;

   // Reset causes come from pins, so they pass two flops first.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         external_master_clear_sync <= 2'h0;
         wdt_sync <= 2'h0;
      end else begin
         external_master_clear_sync <= {external_master_clear_sync[0], external_master_clear};
         wdt_sync <= {wdt_sync[0], watchdog_timeout};
      end
   end
   assign abort_seen = external_master_clear_sync[1] | wdt_sync[1];

   // Operation decode from the stored code and selects.
   always_comb begin
      do_erase = 1'b0;
      do_write = 1'b0;
      span = '0;
      if (control[eeprom_ctl_pkg::BIT_ERASE_SEL]) begin
         do_erase = 1'b1;
         if (control[5:0] == eeprom_ctl_pkg::OP_ERASE_8) begin
            span = AW'(7);
         end else if (control[5:0] == eeprom_ctl_pkg::OP_ERASE_4) begin
            span = AW'(3);
         end else if (control[5:0] == eeprom_ctl_pkg::OP_ERASE_1) begin
            span = '0;
         end else if (control[5:2] == eeprom_ctl_pkg::OP_BULK_TOP) begin
            span = '1;
         end else begin
            do_erase = 1'b0;
         end
      end else if (control[5:2] == eeprom_ctl_pkg::OP_WRITE_TOP) begin
         do_write = 1'b1;
      end
   end

   // Unlock sequencer: the window lasts exactly one cycle after AAh.
   always_comb begin
      next_key = NONE;
      if (reg_write && reg_addr == eeprom_ctl_pkg::ADDR_KEY) begin
         if (reg_wdata[7:0] == eeprom_ctl_pkg::KEY_FIRST) begin
            next_key = GOT_FIRST;
         end else if (key == GOT_FIRST
            && reg_wdata[7:0] == eeprom_ctl_pkg::KEY_SECOND) begin
            next_key = OPEN;
         end
      end
   end

   // Control register, target address, latch, state and timer.
   always_comb begin
      next_state = state;
      next_control = control;
      next_target = target;
      next_latch = latch;
      next_count = count;
      next_flag = flag;
      if (table_write) begin
         next_target = {table_address[23:1], 1'b0};
         next_latch = table_wdata;
      end
      if (reg_write && reg_addr == eeprom_ctl_pkg::ADDR_TARGET_LOW) begin
         next_target[15:0] = {reg_wdata[15:1], 1'b0};
      end
      if (reg_write && reg_addr == eeprom_ctl_pkg::ADDR_TARGET_HIGH) begin
         next_target[23:16] = reg_wdata[7:0];
      end
      if (reg_write && reg_addr == eeprom_ctl_pkg::ADDR_STATUS
         && reg_wdata[0]) begin
         next_flag = 1'b0;
      end
      case (state)
         IDLE: begin
            next_count = '0;
            if (reg_write && reg_addr == eeprom_ctl_pkg::ADDR_CONTROL
               && state == IDLE) begin
               // The trigger is masked off, so only a start can set it;
               // bits 11 to 7 are masked too, so they always read zero.
               next_control = reg_wdata
                  & eeprom_ctl_pkg::CONTROL_WRITABLE;
               if (start_ok) begin
                  next_control[eeprom_ctl_pkg::BIT_TRIGGER] = 1'b1;
                  next_control[eeprom_ctl_pkg::BIT_ERROR] = 1'b0;
                  next_state = RUN;
               end
            end
         end
         RUN: begin
            next_count = count + 32'h1;
            if (abort_seen) begin
               next_control[eeprom_ctl_pkg::BIT_ERROR] = 1'b1;
               next_control[eeprom_ctl_pkg::BIT_TRIGGER] = 1'b0;
               next_control[eeprom_ctl_pkg::BIT_ENABLE] = 1'b0;
               next_state = IDLE;
            end else if (finish) begin
               next_control[eeprom_ctl_pkg::BIT_TRIGGER] = 1'b0;
               next_control[eeprom_ctl_pkg::BIT_ENABLE] = 1'b0;
               next_flag = 1'b1;
               next_state = IDLE;
            end
         end
         default: next_state = IDLE;
      endcase
   end

   // Register read mux; the key port reads zero.
   always_comb begin
      next_rdata = '0;
      if (reg_read) begin
         case (reg_addr)
            eeprom_ctl_pkg::ADDR_CONTROL: next_rdata = control;
            eeprom_ctl_pkg::ADDR_TARGET_LOW: next_rdata = target[15:0];
            eeprom_ctl_pkg::ADDR_TARGET_HIGH:
               next_rdata = {8'h00, target[23:16]};
            eeprom_ctl_pkg::ADDR_LATCH: next_rdata = latch;
            eeprom_ctl_pkg::ADDR_STATUS: next_rdata = {15'h0000, flag};
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= IDLE;
         key <= NONE;
         control <= eeprom_ctl_pkg::CONTROL_RESET;
         target <= '0;
         latch <= '0;
         count <= '0;
         flag <= 1'b0;
         reg_rdata <= '0;
      end else begin
         state <= next_state;
         key <= next_key;
         control <= next_control;
         target <= next_target;
         latch <= next_latch;
         count <= next_count;
         flag <= next_flag;
         reg_rdata <= next_rdata;
      end
   end
   assign completion_interrupt_flag = flag;

   // Array commit at completion; one entry per word.
   genvar gi;
   generate
      for (gi = 0; gi < WORDS; gi++) begin : g_word
         always_ff @(posedge clk) begin
            if (finish && !abort_seen) begin
               if (do_erase && ((AW'(gi) & ~span) == (tidx & ~span))) begin
                  mem[gi] <= eeprom_ctl_pkg::ERASED_WORD;
               end else if (do_write && AW'(gi) == tidx) begin
                  // Pre-erase then program equals the latch; program only
                  // can only clear bits.
                  mem[gi] <= control[eeprom_ctl_pkg::BIT_SKIP_ERASE]
                     ? (mem[gi] & latch) : latch;
               end
            end
         end
      end
   endgenerate

   // Table read from the array window; outside it reads zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         table_rdata <= '0;
      end else if (table_read
         && table_read_address >= eeprom_ctl_pkg::EE_BASE
         && table_read_address <= eeprom_ctl_pkg::EE_LAST) begin
         table_rdata <= mem[table_read_address[AW:1]];
      end else begin
         table_rdata <= '0;
      end
   end

   // Guards on the unlock window, the start conditions and completion.
   a_window_once: assert property (
      @(posedge clk) disable iff (!rst_n)
      key == OPEN |=> key != OPEN)
      else $error("window open too long");
   a_no_start: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == IDLE && key != OPEN |=> state == IDLE)
      else $error("start without unlock");
   a_enable_need: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == IDLE && !control[eeprom_ctl_pkg::BIT_ENABLE] |=> state == IDLE)
      else $error("start without enable");
   a_done_clear: assert property (
      @(posedge clk) disable iff (!rst_n)
      finish && !abort_seen |=> flag
      && !control[eeprom_ctl_pkg::BIT_TRIGGER]
      && !control[eeprom_ctl_pkg::BIT_ENABLE])
      else $error("completion bits wrong");
   a_abort_err: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == RUN && abort_seen |=> control[eeprom_ctl_pkg::BIT_ERROR])
      else $error("abort not flagged");
   a_unimpl_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      control[11:7] == 5'h00)
      else $error("unimplemented bits set");
   a_trig_busy: assert property (
      @(posedge clk) disable iff (!rst_n)
      control[eeprom_ctl_pkg::BIT_TRIGGER] == (state == RUN))
      else $error("trigger mismatch");
   a_addr_even: assert property (
      @(posedge clk) disable iff (!rst_n)
      target[0] == 1'b0)
      else $error("odd target");
endmodule // eeprom_ctl
`default_nettype wire

// ==== hw/eeprom_ctl_pkg.sv ====
// Purpose: Shared constants for the data EEPROM program/erase controller.
// Assumes: Registers are reached over a plain strobe port, one word each.
// Notes: Offsets are word indices on the register port.
`default_nettype none
package eeprom_ctl_pkg;
   // Register map.
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_KEY = 4'h1;
   localparam logic [3:0] ADDR_TARGET_LOW = 4'h2;
   localparam logic [3:0] ADDR_TARGET_HIGH = 4'h3;
   localparam logic [3:0] ADDR_LATCH = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h5;
   // Control field positions.
   localparam int BIT_TRIGGER = 15;
   localparam int BIT_ENABLE = 14;
   localparam int BIT_ERROR = 13;
   localparam int BIT_SKIP_ERASE = 12;
   localparam int BIT_ERASE_SEL = 6;
   localparam logic [15:0] CONTROL_WRITABLE = 16'h707f;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   // Unlock key bytes.
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   // Operation codes.
   localparam logic [5:0] OP_ERASE_8 = 6'h1a;
   localparam logic [5:0] OP_ERASE_4 = 6'h19;
   localparam logic [5:0] OP_ERASE_1 = 6'h18;
   localparam logic [3:0] OP_BULK_TOP = 4'h4;
   localparam logic [3:0] OP_WRITE_TOP = 4'h1;
   // Data EEPROM window in program space.
   localparam logic [23:0] EE_BASE = 24'h7ffe00;
   localparam logic [23:0] EE_LAST = 24'h7fffff;
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   // Self-timed operation length.
   localparam int OP_TIME_NS = 4000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ==== verification/test_data_eeprom_program_erase_control.sv ====
// Purpose: Self-checking bench for the data EEPROM erase/write control.
// Assumes: Operation length is shortened to OPL cycles by parameter.
// Notes: Erase targets are block aligned, so block placement is unambiguous.
`default_nettype none
module test_data_eeprom_program_erase_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OPL = 8;
   logic clk, rst_n, reg_write, reg_read, table_write, table_read, busy;
   logic external_master_clear, watchdog_timeout, completion_interrupt_flag;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, table_wdata, table_rdata, latch;
   logic [23:0] table_address, table_read_address;
   logic [15:0] mem [256];
   logic [15:0] undef [3] = '{16'h407f, 16'h405b, 16'h4008};
   int erase_at [3] = '{16, 36, 45};
   int miscompares = 0;
   int n_checks = 0;
   int seed = 22799;
   int tidx;

   // Controller with a short self-timed operation.
   eeprom_ctl #(.WORDS(256), .OP_LEN(OPL)) dut (
      .clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .table_write, .table_address, .table_wdata, .table_read,
      .table_read_address, .table_rdata, .external_master_clear,
      .watchdog_timeout, .completion_interrupt_flag, .busy
   );

   // Free-running 125 MHz clock.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Verdict and the compare tasks, one per kind of result.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk16(input string what, input logic [15:0] e, g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk1(input string what, input logic e, g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask

   // Register port cycles; a write leaves its strobe up so writes can chain.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      reg_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic idle();
      reg_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [15:0] e,
                        input logic [15:0] m = 16'hffff);
      reg_addr <= a;
      reg_read <= 1'b1;
      reg_write <= 1'b0;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      chk16($sformatf("register %0h", a), e, reg_rdata & m);
      @(posedge clk);
   endtask

   // Table side: read one word, or load the latch and target address.
   task automatic trdchk(input logic [23:0] a, input logic [15:0] e);
      table_read_address <= a;
      table_read <= 1'b1;
      @(posedge clk);
      table_read <= 1'b0;
      @(negedge clk);
      chk16($sformatf("word at %h", a), e, table_rdata);
      @(posedge clk);
   endtask
   task automatic sweep();
      for (int i = 0; i < 256; i++)
         trdchk(eeprom_ctl_pkg::EE_BASE + 24'(2 * i), mem[i]);
   endtask
   task automatic load(input int idx, input logic [15:0] d);
      logic [23:0] a;
      a = eeprom_ctl_pkg::EE_BASE + 24'(2 * idx) + 24'($random(seed) & 1);
      tidx = idx;
      latch = d;
      table_address <= a;
      table_wdata <= d;
      table_write <= 1'b1;
      @(posedge clk);
      table_write <= 1'b0;
      @(posedge clk);
      rdchk(eeprom_ctl_pkg::ADDR_TARGET_LOW, {a[15:1], 1'b0});
      rdchk(eeprom_ctl_pkg::ADDR_TARGET_HIGH, {8'h00, a[23:16]});
      rdchk(eeprom_ctl_pkg::ADDR_LATCH, d);
   endtask

   // Setup, key pair and trigger; a gap or a poke while busy is optional.
   task automatic launch(input logic [15:0] s, input bit poke = 0,
                         input logic [7:0] k1 = 8'h55, k2 = 8'haa,
                         input bit gap = 0);
      wr(eeprom_ctl_pkg::ADDR_CONTROL, s);
      // Nothing else touches the port between the keys, as with
      // interrupts held off.
      wr(eeprom_ctl_pkg::ADDR_KEY, {8'h00, k1});
      wr(eeprom_ctl_pkg::ADDR_KEY, {8'h00, k2});
      if (gap)
         idle();
      wr(eeprom_ctl_pkg::ADDR_CONTROL, s | 16'h8000);
      if (poke)
         wr(eeprom_ctl_pkg::ADDR_CONTROL, 16'h0000);
      idle();
      idle();
   endtask
   task automatic refuse(input logic [15:0] s, input logic [7:0] k1, k2,
                         input bit gap);
      launch(s, 0, k1, k2, gap);
      @(negedge clk);
      chk1("busy", 1'b0, busy);
      @(posedge clk);
      rdchk(eeprom_ctl_pkg::ADDR_CONTROL, s & 16'h507f);
   endtask
   task automatic wait_idle();
      int c;
      c = 0;
      @(negedge clk);
      while (busy !== 1'b0 && c < 100) begin
         @(negedge clk);
         c++;
      end
      chk1("busy released", 1'b0, busy);
      @(posedge clk);
   endtask

   // Completion of a started operation; the array model follows the code.
   task automatic done(input logic [15:0] s);
      int c;
      int k;
      c = 0;
      k = s[1:0] == 2'b10 ? 8 : s[1:0] == 2'b01 ? 4 : 1;
      @(negedge clk);
      chk1("busy at start", 1'b1, busy);
      while (busy === 1'b1 && c < 100) begin
         @(negedge clk);
         c++;
      end
      chk1("op length", 1'b1, c > OPL - 4 && c < OPL + 3);
      @(posedge clk);
      if (s[6] && s[5:2] == 4'h4)
         mem = '{default: 16'hffff};
      else if (s[6] && s[5:2] == 4'h6)
         for (int i = 0; i < k; i++)
            mem[(tidx & ~(k - 1)) + i] = 16'hffff;
      else if (!s[6] && s[5:2] == 4'h1)
         mem[tidx] = s[12] ? mem[tidx] & latch : latch;
      rdchk(eeprom_ctl_pkg::ADDR_CONTROL, s & 16'h107f);
      chk1("done flag", 1'b1, completion_interrupt_flag);
      rdchk(eeprom_ctl_pkg::ADDR_STATUS, 16'h0001);
      wr(eeprom_ctl_pkg::ADDR_STATUS, 16'h0001);
      idle();
      // The status register must show the clear took effect.
      rdchk(eeprom_ctl_pkg::ADDR_STATUS, 16'h0000);
   endtask

   // Cut a hang short; the tests need far less than this span.
   initial begin
      #400000;
      miscompares++;
      end_of_test();
   end

   // Reset, refusals, writes, erases, undefined codes and aborts.
   initial begin
      rst_n = 1'b0;
      {reg_write, reg_read, table_write, table_read} = '0;
      {external_master_clear, watchdog_timeout} = '0;
      {reg_addr, reg_wdata, table_address, table_wdata} = '0;
      table_read_address = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdchk(eeprom_ctl_pkg::ADDR_CONTROL, 16'h0000);
      wr(eeprom_ctl_pkg::ADDR_KEY, 16'h0055);
      idle();
      rdchk(eeprom_ctl_pkg::ADDR_KEY, 16'h0000);
      rdchk(4'hf, 16'h0000);
      wr(eeprom_ctl_pkg::ADDR_CONTROL, 16'hdfff);
      idle();
      rdchk(eeprom_ctl_pkg::ADDR_CONTROL, 16'h507f);
      refuse(16'h0058, 8'h55, 8'haa, 0);
      refuse(16'h4058, 8'haa, 8'h55, 0);
      refuse(16'h4058, 8'h55, 8'haa, 1);
      for (int b = 0; b < 4; b++) begin
         load(b * 9, 16'($random(seed)));
         launch(16'h4004 | 16'(b));
         done(16'h4004 | 16'(b));
         launch(16'h4050 | 16'(b));
         done(16'h4050 | 16'(b));
         sweep();
      end
      for (int i = 8; i < 48; i++) begin
         load(i, 16'($random(seed)));
         launch(16'h4004 | 16'(i % 4), i == 8);
         done(16'h4004 | 16'(i % 4));
      end
      load(20, 16'($random(seed)));
      launch(16'h5004);
      done(16'h5004);
      for (int j = 0; j < 3; j++) begin
         load(erase_at[j], 16'h0000);
         launch(16'h405a - 16'(j));
         done(16'h405a - 16'(j));
      end
      sweep();
      foreach (undef[j]) begin
         load(50 + j, 16'h0000);
         launch(undef[j]);
         wait_idle();
         wr(eeprom_ctl_pkg::ADDR_STATUS, 16'h0001);
         idle();
      end
      sweep();
      for (int src = 0; src < 2; src++) begin
         load(60 + src, 16'($random(seed)));
         launch(16'h4004);
         @(posedge clk);
         if (src == 0)
            watchdog_timeout <= 1'b1;
         else
            external_master_clear <= 1'b1;
         repeat (4) @(posedge clk);
         {watchdog_timeout, external_master_clear} <= 2'b00;
         wait_idle();
         rdchk(eeprom_ctl_pkg::ADDR_CONTROL, 16'h2000, 16'h2000);
         chk1("abort flag", 1'b0, completion_interrupt_flag);
         launch(16'h4004);
         done(16'h4004);
      end
      sweep();
      trdchk(24'h000100, 16'h0000);
      trdchk(24'h800000, 16'h0000);
      end_of_test();
   end
endmodule // test_data_eeprom_program_erase_control
`default_nettype wire
